/* src/cmp_skip_pkg.sv */
// Constants and carrier types for the compare/skip and complement unit.
// Assumes an 8-bit data path and a four-phase instruction cycle.
package cmp_skip_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int PHASES = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // Opcode fields of the upper instruction byte
  localparam logic [6:0] OPC_CMPEQ = 7'h31;
  localparam logic [5:0] OPC_COMP = 6'h07;
  localparam int OPC_HI = 15;
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;

  // Access bank: addresses below 60h map to bank 0, the rest to bank 15
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [1:0] IDLE_RESET = 2'h0;

  // Idle cycles after a taken skip
  localparam logic [1:0] SKIP_ONE_WORD = 2'h1;
  localparam logic [1:0] SKIP_TWO_WORD = 2'h2;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic twoWord;
  } fetch_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_wr_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_IDLE = 2'b01
  } state_t;

endpackage : cmp_skip_pkg

/* src/bank_addr_gen.sv */
// Forms a full data-memory address from an 8-bit operand.
// Assumes the bank select value is held stable by the core.
`timescale 1ns/1ns
module bank_addr_gen
  import cmp_skip_pkg::*;
(
  // Operand
  input wire logic [7:0] fileAddr,
  input wire logic accessBit,
  // Bank select
  input wire logic [3:0] bank_select_reg,
  // Result
  output logic [ADDR_W-1:0] memAddr
);

  always_comb
  begin
    if (accessBit)
    begin
      memAddr = {bank_select_reg, fileAddr};
    end
    else if (fileAddr < ACCESS_SPLIT)
    begin
      memAddr = {ACCESS_LO_BANK, fileAddr};
    end
    else
    begin
      memAddr = {ACCESS_HI_BANK, fileAddr};
    end
  end

endmodule : bank_addr_gen

/* src/compare_equal_skip_exec.sv */
// Executes the equality compare-and-skip and the complement instruction.
// Assumes fetch presents one word per instruction cycle and data memory
// reads combinationally.
//
// Summary of operation
// - Compare byte with accumulator, store nothing
// - On equality, discard fetched instruction, run no-op
// - One cycle, two when skipping one word
// - Three cycles when skipping two-word instruction
// - Two full idle cycles over two-word skip
// - Destination zero: complement into accumulator only
// - Destination one: complement back to register
// - Access bit selects access bank or bank
`timescale 1ns/1ns
module compare_equal_skip_exec
  import cmp_skip_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Fetch stage
  input wire fetch_t fetch,
  output logic fetchAccept,
  // Bank select
  input wire logic [3:0] bank_select_reg,
  // Data memory
  output logic [ADDR_W-1:0] rdAddr,
  input wire logic [DATA_W-1:0] rdData,
  output mem_wr_t memWr,
  // Status flags
  output logic [1:0] statusWe,
  output logic negFlag,
  output logic zeroFlag,
  // Observation
  output logic [DATA_W-1:0] accumulator_file_alias,
  output logic [1:0] phase,
  output logic execBusy,
  output logic skipTaken
);

  state_t state;
  state_t next_state;
  logic [1:0] idleLeft;
  logic [1:0] next_idleLeft;
  logic [1:0] next_phase;
  logic [DATA_W-1:0] next_acc;
  mem_wr_t next_memWr;
  logic [1:0] next_statusWe;
  logic next_negFlag;
  logic next_zeroFlag;
  logic next_skipTaken;
  logic cycleEnd;
  logic isCmp;
  logic isComp;
  logic [DATA_W:0] diff;
  logic [DATA_W-1:0] compl;

  function automatic logic opMatch(input logic [15:0] w, input int width,
                                   input logic [6:0] code);
    logic [6:0] hi;
    hi = 7'(w[OPC_HI -: 7] >> (7 - width));
    opMatch = (hi == 7'(code));
  endfunction : opMatch

  bank_addr_gen u_bank
  (
    .fileAddr(fetch.word[7:0]),
    .accessBit(fetch.word[ACCESS_BIT]),
    .bank_select_reg(bank_select_reg),
    .memAddr(rdAddr)
  );

  assign cycleEnd = (phase == PHASE_LAST);
  assign isCmp = fetch.valid && opMatch(fetch.word, 7, OPC_CMPEQ);
  assign isComp = fetch.valid && opMatch(fetch.word, 6, {1'b0, OPC_COMP});
  // Subtraction result only drives the equality test
  assign diff = {1'b0, rdData} - {1'b0, accumulator_file_alias};
  assign compl = ~rdData;
  assign execBusy = (state == ST_IDLE);
  // Word taken at the end of a cycle; discarded words are still consumed
  assign fetchAccept = cycleEnd && fetch.valid &&
                       (state == ST_RUN || idleLeft == SKIP_ONE_WORD);

  // Phase counter: four phases make one instruction cycle, and nothing
  // stalls it, so fetch can rely on a fixed accept slot
  always_comb
  begin
    next_phase = 2'(phase + 2'h1);
  end

  // Reset puts the unit at phase 0, so the first word is taken on the
  // fourth edge after release
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase <= 2'h0;
    end
    else
    begin
      phase <= next_phase;
    end
  end

  // Sequencer: run cycles and the idle cycles of a taken skip
  always_comb
  begin
    next_state = state;
    next_idleLeft = idleLeft;
    next_skipTaken = skipTaken;
    if (cycleEnd)
    begin
      // skipTaken flags only the first idle cycle after a skip
      next_skipTaken = 1'b0;
      case (state)
        ST_RUN:
        begin
          if (isCmp && diff == '0)
          begin
            next_state = ST_IDLE;
            next_skipTaken = 1'b1;
            // Idle length starts at one cycle; a two-word discarded word adds one later
            next_idleLeft = SKIP_ONE_WORD;
          end
          // A compare that misses, and any other word, keeps running
        end
        ST_IDLE:
        begin
          // The discarded word is seen at the end of the first idle
          // cycle; a two-word one keeps the unit idle one cycle more, in
          // which its second word is consumed without effect
          if (skipTaken && fetch.valid && fetch.twoWord)
          begin
            next_idleLeft = SKIP_ONE_WORD;
          end
          else
          begin
            next_state = ST_RUN;
            next_idleLeft = IDLE_RESET;
          end
        end
        default:
        begin
          // Unused code: recover to running
          next_state = ST_RUN;
          next_idleLeft = IDLE_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_RUN;
      idleLeft <= IDLE_RESET;
      skipTaken <= 1'b0;
    end
    else
    begin
      state <= next_state;
      idleLeft <= next_idleLeft;
      skipTaken <= next_skipTaken;
    end
  end

  // Datapath: accumulator, write-back port and status flags. Only a
  // complement executed in a run cycle touches them; a compare and every
  // idle cycle leave all of them as they are.
  always_comb
  begin
    next_acc = accumulator_file_alias;
    next_memWr = '0;
    next_statusWe = 2'h0;
    next_negFlag = negFlag;
    next_zeroFlag = zeroFlag;
    if (cycleEnd && state == ST_RUN && isComp)
    begin
      // Status carries the sign and zero state of the complement
      next_statusWe = 2'h3;
      next_negFlag = compl[DATA_W-1];
      next_zeroFlag = (compl == '0);
      if (!fetch.word[DEST_BIT])
      begin
        // Source register is not written on this path
        next_acc = compl;
      end
      else
      begin
        // Write-back is a one-clock pulse; the address is taken from the
        // same decode so the result lands in the register just read
        next_memWr.we = 1'b1;
        next_memWr.addr = rdAddr;
        next_memWr.data = compl;
      end
    end
  end

  // Flags reset clear; they change only on a complement
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      accumulator_file_alias <= ACC_RESET;
      memWr <= '0;
      statusWe <= 2'h0;
      negFlag <= 1'b0;
      zeroFlag <= 1'b0;
    end
    else
    begin
      accumulator_file_alias <= next_acc;
      memWr <= next_memWr;
      statusWe <= next_statusWe;
      negFlag <= next_negFlag;
      zeroFlag <= next_zeroFlag;
    end
  end

endmodule : compare_equal_skip_exec

/* verif/cmp_skip_asserts.sv */
// Port checker for the compare/skip unit.
// Assumes it is bound to the execution unit.
`timescale 1ns/1ns
module cmp_skip_asserts
  import cmp_skip_pkg::*;
(
  // Watched ports
  input wire logic mclk,
  input wire logic rstn,
  input wire fetch_t fetch,
  input wire logic fetchAccept,
  input wire logic [3:0] bank_select_reg,
  input wire logic [ADDR_W-1:0] rdAddr,
  input wire logic [DATA_W-1:0] rdData,
  input wire mem_wr_t memWr,
  input wire logic [1:0] statusWe,
  input wire logic negFlag,
  input wire logic zeroFlag,
  input wire logic [DATA_W-1:0] accumulator_file_alias,
  input wire logic execBusy,
  input wire logic skipTaken
);
  logic [7:0] acc, f;
  logic go, cmp, inv, eq, nxt;
  assign acc = accumulator_file_alias;
  assign f = fetch.word[7:0];
  assign go = fetchAccept && fetch.valid && !execBusy;
  assign cmp = go && fetch.word[OPC_HI:9] == OPC_CMPEQ;
  assign inv = go && fetch.word[OPC_HI:10] == OPC_COMP;
  assign eq = rdData == acc;
  assign nxt = skipTaken && fetchAccept;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_cmp_quiet: assert property (
    cmp |=> !memWr.we && statusWe == 2'h0 && $stable(acc))
    else $error("compare changed state");
  a_cmp_flags: assert property (
    cmp |=> $stable(negFlag) && $stable(zeroFlag))
    else $error("compare changed flags");
  a_skip_eq: assert property (
    cmp |=> execBusy == $past(eq) && skipTaken == execBusy)
    else $error("skip decision wrong");
  a_one_word: assert property (
    nxt && !fetch.twoWord |=> !execBusy) else $error("idle too long");
  a_two_word: assert property (
    nxt && fetch.twoWord |=> execBusy [*4] ##1 !execBusy)
    else $error("two-word skip length wrong");
  a_idle_nop: assert property (
    execBusy |-> !memWr.we && statusWe == 2'h0 && $stable(acc))
    else $error("idle cycle did work");
  a_inv_acc: assert property (
    inv && !fetch.word[DEST_BIT] |=> acc == ~$past(rdData) && !memWr.we)
    else $error("complement to accumulator wrong");
  a_inv_reg: assert property (
    inv && fetch.word[DEST_BIT] |=> memWr.we && $stable(acc)
    && memWr.data == ~$past(rdData) && memWr.addr == $past(rdAddr))
    else $error("complement write-back wrong");
  a_bank_sel: assert property (
    fetch.valid |-> rdAddr == {fetch.word[ACCESS_BIT] ? bank_select_reg :
    f < ACCESS_SPLIT ? ACCESS_LO_BANK : ACCESS_HI_BANK, f})
    else $error("bank address wrong");
  cover property (cmp && eq);
  cover property (nxt && fetch.twoWord);
  cover property (inv && fetch.word[DEST_BIT]);
endmodule : cmp_skip_asserts

/* verif/dmem_model.sv */
// Behavioural data memory behind the execution unit.
// Assumes writes arrive as registered pulses; reads are immediate.
`timescale 1ns/1ns
module dmem_model
  import cmp_skip_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Memory side
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData,
  input wire mem_wr_t memWr
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  assign rdData = mem[rdAddr];
  always @(posedge mclk)
    if (memWr.we)
      mem[memWr.addr] <= memWr.data;
endmodule : dmem_model

/* verif/compare_equal_skip_exec_tb_top.sv */
// Self-checking bench for the compare/skip unit.
// Assumes the memory model is preloaded by hierarchical writes.
`timescale 1ns/1ns
module compare_equal_skip_exec_tb_top;
  import cmp_skip_pkg::*;
  logic mclk, rstn, fetchAccept, negFlag, zeroFlag, execBusy, skipTaken;
  fetch_t fetch;
  mem_wr_t memWr;
  logic [3:0] bank_select_reg;
  logic [ADDR_W-1:0] rdAddr;
  logic [7:0] rdData, acc;
  logic [1:0] statusWe, phase;
  int fails, cmp_count;
  compare_equal_skip_exec dut_u (.mclk, .rstn, .fetch, .fetchAccept,
    .bank_select_reg, .rdAddr, .rdData, .memWr, .statusWe, .negFlag,
    .zeroFlag, .accumulator_file_alias(acc), .phase, .execBusy, .skipTaken);
  dmem_model mem_u (.mclk, .rdAddr, .rdData, .memWr);
  task chk(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask : chk
  // Hangs here are cut by the watchdog
  task put(input logic [15:0] w, input logic tw);
    fetch = '{1'b1, w, tw};
    @(negedge mclk);
    while (fetchAccept !== 1'b1)
      @(negedge mclk);
    @(posedge mclk);
    #1;
  endtask : put
  task t_comp;
    mem_u.mem[12'h010] = 8'h13;
    mem_u.mem[12'hf80] = 8'h0f;
    mem_u.mem[12'h5a0] = 8'h5a;
    bank_select_reg = 4'h5;
    put(16'h1c10, 1'b0);
    chk("acc", 8'hec, acc);
    chk("neg", 8'h1, {7'h0, negFlag});
    chk("statusWe", 8'h3, {6'h0, statusWe});
    chk("phase", 8'h0, {6'h0, phase});
    chk("src", 8'h13, mem_u.mem[12'h010]);
    put(16'h1e80, 1'b0);
    put(16'h1fa0, 1'b0);
    chk("bank15", 8'hf0, mem_u.mem[12'hf80]);
    put(16'h0000, 1'b0);
    chk("bank", 8'ha5, mem_u.mem[12'h5a0]);
    chk("acc", 8'hec, acc);
    mem_u.mem[12'h011] = 8'hff;
    put(16'h1e11, 1'b0);
    chk("zero", 8'h1, {7'h0, zeroFlag});
    chk("neg", 8'h0, {7'h0, negFlag});
  endtask : t_comp
  task t_skip_one;
    mem_u.mem[12'h020] = 8'heb;
    mem_u.mem[12'h021] = 8'h55;
    put(16'h6220, 1'b0);
    chk("busy", 8'h0, {7'h0, execBusy});
    chk("zero", 8'h1, {7'h0, zeroFlag});
    chk("neg", 8'h0, {7'h0, negFlag});
    put(16'h1c21, 1'b0);
    mem_u.mem[12'h030] = 8'haa;
    put(16'h6230, 1'b0);
    chk("busy", 8'h1, {7'h0, execBusy});
    chk("zero", 8'h0, {7'h0, zeroFlag});
    put(16'h1c10, 1'b0);
    chk("acc", 8'haa, acc);
    chk("busy", 8'h0, {7'h0, execBusy});
  endtask : t_skip_one
  task t_skip_two;
    mem_u.mem[12'h530] = 8'haa;
    put(16'h6330, 1'b0);
    put(16'h1c10, 1'b1);
    chk("busy", 8'h1, {7'h0, execBusy});
    put(16'h1c10, 1'b0);
    chk("acc", 8'haa, acc);
    chk("busy", 8'h0, {7'h0, execBusy});
    put(16'h1c10, 1'b0);
    chk("acc", 8'hec, acc);
  endtask : t_skip_two
  task print_verdict;
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    #20000;
    fails++;
    print_verdict;
  end
  initial
  begin
    rstn = 1'b0;
    fetch = '0;
    bank_select_reg = 4'h0;
    repeat (3) @(posedge mclk);
    #1;
    rstn = 1'b1;
    chk("acc", ACC_RESET, acc);
    t_comp;
    t_skip_one;
    t_skip_two;
    print_verdict;
  end
endmodule : compare_equal_skip_exec_tb_top
bind compare_equal_skip_exec cmp_skip_asserts chk_u (.mclk, .rstn, .fetch,
  .fetchAccept, .bank_select_reg, .rdAddr, .rdData, .memWr, .statusWe,
  .negFlag, .zeroFlag, .accumulator_file_alias, .execBusy, .skipTaken);
